// [rtl/cir_regs.sv]
// Controller identity register bank with two read ports
//
// Notes on behaviour
// - An 8-bit read-only type code sits at offset zero for both sides.
// - An 8-bit revision sits at offset one, equal to the major version.
// - Build holds maintenance in 3:0, minor in 7:4, patch in 15:8.
// - Patch byte is zero original, 1 to 15 patch, 16 up development.
// - Offset four reports the number of mapping unit channels.
// - Offset five reports the number of buffer sync unit channels.
// - Offset six reports process RAM size in kilobytes, 0 to 60.
// - Offset seven holds four 2-bit port fields, port 0 lowest.
// - Port codes are absent, unconfigured, backplane and MII family.
// - Multi-byte registers keep the low byte at the lower address.
`timescale 1ns/1ps
module cir_regs
  import cir_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] MAJOR_VER = 8'h01,
  parameter logic [3:0] MINOR_VER = 4'h0,
  parameter logic [3:0] MAINT_VER = 4'h0,
  parameter logic [7:0] PATCH_LVL = 8'h00,
  parameter logic [7:0] MAP_UNITS = 8'h08,
  parameter logic [7:0] SYNC_UNITS = 8'h08,
  parameter logic [7:0] RAM_KB = 8'h08,
  parameter logic [7:0] PORT_CFG = 8'hFF
) (
  input wire logic clk, // 40 MHz core clock
  input wire logic rst, // Async reset, high
  input wire cir_req_t net_req, // Network side access
  output cir_rsp_t net_rsp, // Network side answer
  input wire cir_req_t host_req, // Local host access
  output cir_rsp_t host_rsp // Local host answer
);

  // Image of the eight identity bytes, built from configuration
  logic [7:0] img [8];
  logic [15:0] build_val;
  logic [7:0] ram_kb_sat;
  cir_rsp_t net_reg, net_next, host_reg, host_next;

  // Build value assembly, one field per version part
  // The patch byte sits on top so a development build sorts high
  assign build_val = {PATCH_LVL, MINOR_VER, MAINT_VER};
  // RAM size clipped to the largest configurable size
  assign ram_kb_sat = (RAM_KB > CIR_RAM_MAX_KB) ? CIR_RAM_MAX_KB
                                                : RAM_KB;

  // Patch byte class flags; exactly one holds for any build value
  // They let the checks name the class without redoing the compare
  logic patch_is_orig;
  logic patch_is_fix;
  logic patch_is_dev;
  assign patch_is_orig = build_val[15:8] == CIR_PATCH_ORIG;
  assign patch_is_fix = (build_val[15:8] != CIR_PATCH_ORIG) &&
                        (build_val[15:8] <= CIR_PATCH_MAX);
  assign patch_is_dev = build_val[15:8] >= CIR_DEV_MIN;

  // Per-port descriptor fields, decoded one by one and packed back
  // Fields are fixed at build time; no port changes while running
  cir_port_t port_field [CIR_PORTS];
  wire [7:0] port_bits;
  genvar gp;
  generate
    for (gp = 0; gp < CIR_PORTS; gp++) begin : g_port
      // Slices follow the loop index, never hard-wired positions
      assign port_field[gp] =
        cir_port_t'(PORT_CFG[gp*CIR_PORT_W +: CIR_PORT_W]);
      assign port_bits[gp*CIR_PORT_W +: CIR_PORT_W] =
        port_field[gp];
      // Each side reads this port's build setting in its own bits
      port_host_a: assert property (@(posedge clk) disable iff (rst)
        host_req.rd && host_req.addr == CIR_OFF_PORT_DESC |=>
        host_rsp.data[gp*CIR_PORT_W +: CIR_PORT_W] ==
        PORT_CFG[gp*CIR_PORT_W +: CIR_PORT_W])
        else $error("host port field wrong");
      port_net_a: assert property (@(posedge clk) disable iff (rst)
        net_req.rd && net_req.addr == CIR_OFF_PORT_DESC |=>
        net_rsp.data[gp*CIR_PORT_W +: CIR_PORT_W] ==
        PORT_CFG[gp*CIR_PORT_W +: CIR_PORT_W])
        else $error("network port field wrong");
    end
  endgenerate

  // Byte image; low build byte first at the lower address
  // Pure wiring of parameters, so it costs no flip-flops
  always_comb begin
    img[0] = TYPE_CODE;
    img[1] = MAJOR_VER;
    img[2] = build_val[7:0];
    img[3] = build_val[15:8];
    img[4] = MAP_UNITS;
    img[5] = SYNC_UNITS;
    img[6] = ram_kb_sat;
    img[7] = port_bits;
  end

  // Read lookup; unmapped addresses read zero, writes are dropped
  // A write with read also set counts as a read; the write half is lost
  // Only three address bits index the image, the range test guards it
  function automatic cir_rsp_t lookup(input cir_req_t r);
    cir_rsp_t o;
    o.valid = r.rd;
    o.data = 8'h00;
    if (r.rd && r.addr <= CIR_OFF_PORT_DESC) begin
      o.data = img[r.addr[2:0]];
    end
    return o;
  endfunction : lookup

  // Next answers for both sides, computed independently
  // The two sides share no state, so neither can stall the other
  always_comb begin
    net_next = lookup(net_req);
    host_next = lookup(host_req);
  end

  // Answer registers, one cycle after the request
  // Registering keeps both answers straight from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      net_reg <= '0;
      host_reg <= '0;
    end else begin
      net_reg <= net_next;
      host_reg <= host_next;
    end
  end

  assign net_rsp = net_reg;
  assign host_rsp = host_reg;

  // Checks on what each side reads back
  // Expected values come from the build parameters, not the image,
  // so a wrong byte in the image or a crossed decode shows up here
  // Every check is gated by reset except the one that watches the
  // release itself
  // Network side first, one check per identity byte; revision and port descriptor are read on the host side
  sequence net_rd_s(logic [15:0] a);
    net_req.rd && net_req.addr == a;
  endsequence
  type_read_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_TYPE) |=> net_rsp.valid && net_rsp.data == TYPE_CODE)
    else $error("type code read wrong");
  rev_read_a: assert property (@(posedge clk) disable iff (rst)
    host_req.rd && host_req.addr == CIR_OFF_REV |=>
    host_rsp.data == MAJOR_VER) else $error("revision read wrong");
  build_order_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_BUILD_HI) |=> net_rsp.data == PATCH_LVL)
    else $error("build high byte wrong");
  build_low_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_BUILD_LO) |=>
    net_rsp.data == {MINOR_VER, MAINT_VER}) else $error("build low wrong");
  map_count_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_MAP_CNT) |=> net_rsp.data == MAP_UNITS)
    else $error("mapping count wrong");
  sync_count_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_SYNC_CNT) |=> net_rsp.data == SYNC_UNITS)
    else $error("sync count wrong");
  ram_range_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_RAM_SIZE) |=> net_rsp.data <= CIR_RAM_MAX_KB)
    else $error("ram size out of range");
  port_desc_a: assert property (@(posedge clk) disable iff (rst)
    host_req.rd && host_req.addr == CIR_OFF_PORT_DESC |=>
    host_rsp.data == PORT_CFG) else $error("port descriptor wrong");
  write_quiet_a: assert property (@(posedge clk) disable iff (rst)
    net_req.wr && !net_req.rd |=> !net_rsp.valid)
    else $error("write gave an answer");

  // Host side twins, plus the network revision twin; each side decodes its own requests alone, so a
  // fault in one decoder cannot hide behind the other
  sequence host_rd_s(logic [15:0] a);
    host_req.rd && host_req.addr == a;
  endsequence
  host_type_a: assert property (@(posedge clk) disable iff (rst)
    host_rd_s(CIR_OFF_TYPE) |=>
    host_rsp.valid && host_rsp.data == TYPE_CODE)
    else $error("host type code wrong");
  net_rev_a: assert property (@(posedge clk) disable iff (rst)
    net_rd_s(CIR_OFF_REV) |=> net_rsp.data == MAJOR_VER)
    else $error("network revision wrong");
  host_bld_lo_a: assert property (@(posedge clk) disable iff (rst)
    host_rd_s(CIR_OFF_BUILD_LO) |=>
    host_rsp.data == {MINOR_VER, MAINT_VER})
    else $error("host build low wrong");
  host_bld_hi_a: assert property (@(posedge clk) disable iff (rst)
    host_rd_s(CIR_OFF_BUILD_HI) |=> host_rsp.data == PATCH_LVL)
    else $error("host build high wrong");
  host_map_a: assert property (@(posedge clk) disable iff (rst)
    host_rd_s(CIR_OFF_MAP_CNT) |=> host_rsp.data == MAP_UNITS)
    else $error("host mapping count wrong");
  host_sync_a: assert property (@(posedge clk) disable iff (rst)
    host_rd_s(CIR_OFF_SYNC_CNT) |=> host_rsp.data == SYNC_UNITS)
    else $error("host sync count wrong");
  host_ram_a: assert property (@(posedge clk) disable iff (rst)
    host_rd_s(CIR_OFF_RAM_SIZE) |=> host_rsp.data <= CIR_RAM_MAX_KB)
    else $error("host ram size out of range");
  host_quiet_a: assert property (@(posedge clk) disable iff (rst)
    host_req.wr && !host_req.rd |=> !host_rsp.valid)
    else $error("host write gave an answer");

  // A size inside the limit must come through exactly, not clipped
  // The clip only guards a build setting past the largest RAM
  ram_exact_a: assert property (@(posedge clk) disable iff (rst)
    RAM_KB <= CIR_RAM_MAX_KB && net_req.rd &&
    net_req.addr == CIR_OFF_RAM_SIZE |=> net_rsp.data == RAM_KB)
    else $error("ram size not passed through");

  // Answer timing: one valid per read cycle, exactly one cycle late
  sequence net_take_s;
    net_req.rd;
  endsequence
  sequence host_take_s;
    host_req.rd;
  endsequence
  net_valid_a: assert property (@(posedge clk) disable iff (rst)
    net_take_s |=> net_rsp.valid) else $error("network read unanswered");
  host_valid_a: assert property (@(posedge clk) disable iff (rst)
    host_take_s |=> host_rsp.valid) else $error("host read unanswered");
  // No stray byte either, so a lone write leaves the bus at zero
  net_idle_a: assert property (@(posedge clk) disable iff (rst)
    !net_req.rd |=> !net_rsp.valid && net_rsp.data == 8'h00)
    else $error("network answer without read");
  host_idle_a: assert property (@(posedge clk) disable iff (rst)
    !host_req.rd |=> !host_rsp.valid && host_rsp.data == 8'h00)
    else $error("host answer without read");

  // Reads back to back give answers back to back, none swallowed
  // A held answer would hide a lost request from the reader
  net_b2b_a: assert property (@(posedge clk) disable iff (rst)
    net_take_s ##1 net_take_s |-> net_rsp.valid ##1 net_rsp.valid)
    else $error("network back to back lost");
  host_b2b_a: assert property (@(posedge clk) disable iff (rst)
    host_take_s ##1 host_take_s |-> host_rsp.valid ##1 host_rsp.valid)
    else $error("host back to back lost");

  // Addresses past the bank read zero but are still answered
  // Readers must not rely on that zero, it only keeps the bus defined
  net_hole_a: assert property (@(posedge clk) disable iff (rst)
    net_req.rd && net_req.addr > CIR_OFF_PORT_DESC |=>
    net_rsp.valid && net_rsp.data == 8'h00)
    else $error("network hole not zero");
  host_hole_a: assert property (@(posedge clk) disable iff (rst)
    host_req.rd && host_req.addr > CIR_OFF_PORT_DESC |=>
    host_rsp.valid && host_rsp.data == 8'h00)
    else $error("host hole not zero");

  // Both sides see one image, whatever the other side is doing
  both_same_a: assert property (@(posedge clk) disable iff (rst)
    net_req.rd && host_req.rd && net_req.addr == host_req.addr |=>
    net_rsp.data == host_rsp.data) else $error("sides disagree");

  // Write then read of one byte: the write must have changed nothing
  // Catches a write path that sneaks in if the bank ever gains storage
  sequence net_wr_s(logic [15:0] a);
    net_req.wr && !net_req.rd && net_req.addr == a;
  endsequence
  sequence host_wr_s(logic [15:0] a);
    host_req.wr && !host_req.rd && host_req.addr == a;
  endsequence
  net_keep_a: assert property (@(posedge clk) disable iff (rst)
    net_wr_s(CIR_OFF_TYPE) ##1 net_rd_s(CIR_OFF_TYPE) |=>
    net_rsp.data == TYPE_CODE) else $error("write changed type code");
  host_keep_a: assert property (@(posedge clk) disable iff (rst)
    host_wr_s(CIR_OFF_PORT_DESC) ##1 host_rd_s(CIR_OFF_PORT_DESC) |=>
    host_rsp.data == PORT_CFG) else $error("write changed descriptor");

  // Build word read low then high pairs into the 16-bit value
  sequence net_pair_s;
    net_rd_s(CIR_OFF_BUILD_LO) ##1 net_rd_s(CIR_OFF_BUILD_HI);
  endsequence
  sequence host_pair_s;
    host_rd_s(CIR_OFF_BUILD_LO) ##1 host_rd_s(CIR_OFF_BUILD_HI);
  endsequence
  net_pair_a: assert property (@(posedge clk) disable iff (rst)
    net_pair_s |=> net_rsp.data == PATCH_LVL &&
    $past(net_rsp.data) == {MINOR_VER, MAINT_VER})
    else $error("network build word split wrong");
  host_pair_a: assert property (@(posedge clk) disable iff (rst)
    host_pair_s |=> host_rsp.data == PATCH_LVL &&
    $past(host_rsp.data) == {MINOR_VER, MAINT_VER})
    else $error("host build word split wrong");

  // Patch class flags and what the high build byte then reads as
  patch_class_a: assert property (@(posedge clk) disable iff (rst)
    $onehot({patch_is_orig, patch_is_fix, patch_is_dev}))
    else $error("patch class not unique");
  patch_net_a: assert property (@(posedge clk) disable iff (rst)
    patch_is_dev && net_req.rd && net_req.addr == CIR_OFF_BUILD_HI |=>
    net_rsp.data >= CIR_DEV_MIN) else $error("development build hidden");
  patch_host_a: assert property (@(posedge clk) disable iff (rst)
    patch_is_dev && host_req.rd && host_req.addr == CIR_OFF_BUILD_HI |=>
    host_rsp.data >= CIR_DEV_MIN) else $error("host build class hidden");

  // Outputs sit at zero on the first edge after reset lets go;
  // a stale answer here would be taken as a read nobody made
  rst_free_a: assert property (@(posedge clk)
    $fell(rst) |-> !net_rsp.valid && !host_rsp.valid)
    else $error("answer right after reset");
endmodule : cir_regs

// [pkg/cir_pkg.sv]
// Package for the controller identity register bank
package cir_pkg;
  // Byte offsets of the identity registers
  localparam logic [15:0] CIR_OFF_TYPE = 16'h0000;
  localparam logic [15:0] CIR_OFF_REV = 16'h0001;
  localparam logic [15:0] CIR_OFF_BUILD_LO = 16'h0002;
  localparam logic [15:0] CIR_OFF_BUILD_HI = 16'h0003;
  localparam logic [15:0] CIR_OFF_MAP_CNT = 16'h0004;
  localparam logic [15:0] CIR_OFF_SYNC_CNT = 16'h0005;
  localparam logic [15:0] CIR_OFF_RAM_SIZE = 16'h0006;
  localparam logic [15:0] CIR_OFF_PORT_DESC = 16'h0007;
  // Build field positions
  localparam int CIR_BLD_MAINT_LSB = 0;
  localparam int CIR_BLD_MINOR_LSB = 4;
  localparam int CIR_BLD_PATCH_LSB = 8;
  // Patch byte classes
  localparam logic [7:0] CIR_PATCH_ORIG = 8'h00;
  localparam logic [7:0] CIR_PATCH_MAX = 8'h0F;
  localparam logic [7:0] CIR_DEV_MIN = 8'h10;
  // Process RAM size limit in kilobytes
  localparam logic [7:0] CIR_RAM_MAX_KB = 8'h3C;
  // Width of a port descriptor field
  localparam int CIR_PORT_W = 2;
  localparam int CIR_PORTS = 4;
  // Port field encodings
  typedef enum logic [1:0] {
    CIR_PORT_ABSENT = 2'h0,
    CIR_PORT_UNCFG = 2'h1,
    CIR_PORT_BACKPLANE = 2'h2,
    CIR_PORT_MII = 2'h3
  } cir_port_t;
  // One read or write request and its answer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cir_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cir_rsp_t;
endpackage : cir_pkg

// [dv/cir_party.sv]
// Access party model driving one request port
`timescale 1ns/1ps
module cir_party
  import cir_pkg::*;
(
  input wire logic clk, // Core clock
  output cir_req_t req, // Request to bank
  input wire cir_rsp_t rsp // Answer from bank
);
  initial req = '0;
  // Request held to its edge; answer sampled once it has landed
  task automatic xfer(input logic w, input logic [15:0] a,
    output logic [8:0] r);
    req = '{rd: !w, wr: w, addr: a, wdata: 8'($urandom)};
    @(posedge clk);
    #2 r = {rsp.valid, rsp.data};
  endtask : xfer
  // Released lines flip so stale values never pass
  task automatic idle;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : idle
endmodule : cir_party

// [dv/tb.sv]
// Self-checking bench for the identity register bank
`timescale 1ns/1ps
module tb;
  import cir_pkg::*;
  localparam logic [7:0] TC = 8'h5A; // Arbitrary type code
  localparam logic [7:0] PL = 8'h10;
  localparam logic [7:0] RK = 8'h3C;
  localparam logic [7:0] PC = 8'hE4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cir_req_t nq;
  cir_req_t hq;
  cir_rsp_t ns;
  cir_rsp_t hs;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [8:0] rn, rh, rx, ry;
  logic [15:0] an, ah;
  logic wn, wh;
  // Expected bytes: build low is minor 2, maintenance 7
  logic [7:0] regs [8] = '{TC, 8'h03, 8'h27, PL, 8'h03, 8'h04, RK,
    PC};
  // Build settings stand in for the loaded configuration image
  cir_regs #(.TYPE_CODE(TC), .MAJOR_VER(8'h03), .MINOR_VER(4'h2),
    .MAINT_VER(4'h7), .PATCH_LVL(PL), .MAP_UNITS(8'h03),
    .SYNC_UNITS(8'h04), .RAM_KB(RK), .PORT_CFG(PC)) cir_regs_i (
    .clk(clk), .rst(rst), .net_req(nq), .net_rsp(ns),
    .host_req(hq), .host_rsp(hs));
  cir_party net_m (.clk(clk), .req(nq), .rsp(ns));
  cir_party host_m (.clk(clk), .req(hq), .rsp(hs));
  // 25 ns core clock
  always #12.5 clk = ~clk;
  task automatic bad(input logic [15:0] a, input logic [8:0] r);
    n_fail++;
    $display("mismatch at %0t: addr %h got %h", $time, a, r);
  endtask : bad
  // Writes answer nothing; reserved reads only need valid
  task automatic chk(input logic [15:0] a, input logic w,
    input logic [8:0] r);
    comparisons++;
    if (w ? r[8] !== 1'b0 : a < 16'h0008 ? r !== {1'b1, regs[a[2:0]]}
      : r[8] !== 1'b1) bad(a, r);
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Hang guard, run needs about 70 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      n_fail++;
      give_verdict();
    end
  end
  // Random mixed traffic on both sides at once, back to back
  initial begin
    void'($urandom(43357));
    repeat (5) @(posedge clk);
    #2 rst = 1'b0;
    repeat (60) begin
      an = 16'($urandom_range(9));
      ah = 16'($urandom_range(9));
      wn = an < 16'h0008 && $urandom_range(1) == 1;
      wh = ah < 16'h0008 && $urandom_range(1) == 1;
      fork
        net_m.xfer(wn, an, rn);
        host_m.xfer(wh, ah, rh);
      join
      chk(an, wn, rn);
      chk(ah, wh, rh);
    end
    // Write then read back the same byte on each side
    fork
      net_m.xfer(1'b1, 16'h0000, rn);
      host_m.xfer(1'b1, 16'h0007, rh);
    join
    chk(16'h0000, 1'b1, rn);
    chk(16'h0007, 1'b1, rh);
    fork
      net_m.xfer(1'b0, 16'h0000, rn);
      host_m.xfer(1'b0, 16'h0007, rh);
    join
    chk(16'h0000, 1'b0, rn);
    chk(16'h0007, 1'b0, rh);
    // Build word low then high on both sides
    fork
      net_m.xfer(1'b0, 16'h0002, rn);
      host_m.xfer(1'b0, 16'h0002, rx);
    join
    fork
      net_m.xfer(1'b0, 16'h0003, rh);
      host_m.xfer(1'b0, 16'h0003, ry);
    join
    comparisons++;
    if ({rh, rn} !== {1'b1, PL, 1'b1, 8'h27})
      bad(16'h0002, rn);
    comparisons++;
    if ({ry, rx} !== {1'b1, PL, 1'b1, 8'h27})
      bad(16'h0002, rx);
    net_m.idle();
    host_m.idle();
    give_verdict();
  end
endmodule : tb
